// file: rtl/tpos_consts.svh
// Offsets, field positions, reset values and timing counts of the output shaper.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr_i[7:0].
`ifndef TPOS_CONSTS_SVH
`define TPOS_CONSTS_SVH
// Register byte addresses
`define TPOS_CTRL_ADR      8'h00
`define TPOS_STATUS_ADR    8'h04
`define TPOS_SCHED_ADR     8'h08
`define TPOS_MINW_ADR      8'h0C
`define TPOS_MVLIM_ADR     8'h10
`define TPOS_OUT_BASE      8'h20
`define TPOS_OUT_STRIDE    8'h10
`define TPOS_PER_OFS       2'h0
`define TPOS_HI_OFS        2'h1
`define TPOS_LO_OFS        2'h2
`define TPOS_DP_OFS        2'h3
// Field positions
`define TPOS_CTRL_RUN      0
`define TPOS_CTRL_SRST     1
`define TPOS_CTRL_STREQ    2
`define TPOS_SCHED_DLY_LSB 16
// Reset values and ranges
`define TPOS_MINW_RST      10'h00A
`define TPOS_MINW_MAX      10'h1F4
`define TPOS_FULL          11'h3E8
`define TPOS_DLY_RST       11'h00A
`define TPOS_DLY_MAX       11'h3E8
`define TPOS_PER_RST       7'h02
`define TPOS_PER_MAX       7'h63
`define TPOS_HI_RST        16'h0064
`define TPOS_LO_RST        16'h0000
`define TPOS_LIM_MIN       (-1999)
`define TPOS_LIM_MAX       9999
`define TPOS_HALF_CAP      11'h1F4
`define TPOS_QUART_CAP     11'h0FA
// Timing
`define TPOS_CLK_NS        4
`define TPOS_TICK_NS       2000000
`define TPOS_TICK_CYCLES   (`TPOS_TICK_NS / `TPOS_CLK_NS)
`define TPOS_TICKS_PER_S   500
`define TPOS_HALF_S_TICKS  250
`endif

// file: rtl/tpos_pkg.sv
// Types of the time-proportional output shaper.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tpos_pkg;
   typedef enum logic [1:0]
   {
      TPOS_NO_OFFSET = 2'h0,
      TPOS_HALVES    = 2'h1,
      TPOS_QUARTERS  = 2'h2
   } tpos_sched_t;
   typedef logic [10:0] tpos_pct_t;
endpackage : tpos_pkg
`default_nettype wire

// file: rtl/tpos_shaper.sv
// Time-proportional output shaper: percentages in, on/off pulses out, Wishbone registers.
// Assumes inputs synchronous to clk_i and manipulated values in tenths of a percent.
`default_nettype none
`include "tpos_consts.svh"
module tpos_shaper
   import tpos_pkg::*;
#(
   parameter int         N_OUT       = 4,
   parameter int         TICK_CYCLES = `TPOS_TICK_CYCLES,
   parameter bit         TWO_CHAN    = 1'b0,
   parameter bit         PULSE_OUT   = 1'b1,
   parameter logic [3:0] LINEAR_MASK = 4'h0
)
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Wishbone slave
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic [31:0]             dat_o,
   output logic                    ack_o,
   // Control inputs
   input  wire logic [N_OUT*11-1:0] manipulated_value_i,
   input  wire logic [N_OUT-1:0]   assigned_pid_i,
   input  wire logic [N_OUT-1:0]   std_mode_i,
   // Outputs
   output logic [N_OUT-1:0]        pulse_o,
   output logic                    self_tuning_en_o,
   output logic                    sched_active_o
);

   if (N_OUT < 1 || N_OUT > 4 || TICK_CYCLES < 1)
   begin : g_bad_param
      $error("tpos_shaper: unsupported N_OUT or TICK_CYCLES");
   end

   localparam int CW = 17;

   function automatic tpos_pct_t scale_pct(input tpos_pct_t mv, input logic signed [15:0] hi,
                                           input logic signed [15:0] lo, input logic [1:0] dp);
      int pw;
      int num;
      int den;
      int r;
      pw  = (dp == 2'h0) ? 1 : (dp == 2'h1) ? 10 : (dp == 2'h2) ? 100 : 1000;
      den = int'(hi) - int'(lo);
      num = (int'(mv) * pw - 10 * int'(lo)) * 100;
      r   = (den == 0) ? 0 : num / den;
      if (r < 0)
         r = 0;
      if (r > int'(`TPOS_FULL))
         r = int'(`TPOS_FULL);
      return tpos_pct_t'(r);
   endfunction : scale_pct

   // Bus decode
   logic        ack_reg;
   logic [31:0] rd_data;
   logic        run_reg;
   logic        streq_reg;
   logic [9:0]  minw_reg;
   tpos_pct_t   mvlim_reg;
   logic [1:0]  meth_pend_reg;
   logic [10:0] dly_pend_reg;
   logic [1:0]  meth_act_reg;
   logic [10:0] dly_act_reg;
   logic [6:0]  per_reg [N_OUT];
   logic [15:0] hi_reg  [N_OUT];
   logic [15:0] lo_reg  [N_OUT];
   logic [1:0]  dp_reg  [N_OUT];
   logic [31:0] rd_out  [N_OUT];

   wire        req       = cyc_i && stb_i && !ack_reg;
   wire        wr        = req && we_i && (sel_i == 4'hF);
   wire        wr_ctrl   = wr && (adr_i == `TPOS_CTRL_ADR);
   wire        wr_sched  = wr && (adr_i == `TPOS_SCHED_ADR);
   wire        wr_minw   = wr && (adr_i == `TPOS_MINW_ADR);
   wire        wr_mvlim  = wr && (adr_i == `TPOS_MVLIM_ADR);
   wire        soft_rst  = wr_ctrl && dat_i[`TPOS_CTRL_SRST];
   wire        out_hit   = (adr_i >= `TPOS_OUT_BASE)
                           && (adr_i[7:4] - 4'(`TPOS_OUT_BASE >> 4)) < 4'(N_OUT);
   wire [1:0]  out_idx   = 2'(adr_i[7:4] - (`TPOS_OUT_BASE >> 4));
   wire [1:0]  out_fld   = adr_i[3:2];
   wire [1:0]  meth_new  = dat_i[1:0];
   wire [10:0] dly_new   = dat_i[`TPOS_SCHED_DLY_LSB +: 11];
   wire        meth_ok   = (meth_new <= TPOS_QUARTERS) && !(TWO_CHAN && meth_new == TPOS_QUARTERS);
   wire        dly_ok    = dly_new <= `TPOS_DLY_MAX;
   wire        minw_ok   = dat_i[31:10] == 22'h0 && dat_i[9:0] <= `TPOS_MINW_MAX;
   wire        mvlim_ok  = dat_i[31:11] == 21'h0 && dat_i[10:0] <= `TPOS_FULL;
   wire signed [31:0] lim_val = $signed(dat_i);
   wire        lim_ok    = lim_val >= `TPOS_LIM_MIN && lim_val <= `TPOS_LIM_MAX;

   // Scheduling status and cap
   wire        sched_on  = (meth_act_reg != TPOS_NO_OFFSET) && (&std_mode_i)
                           && (&assigned_pid_i) && PULSE_OUT;
   wire [10:0] cap       = (meth_act_reg == TPOS_HALVES) ? `TPOS_HALF_CAP :
                           (meth_act_reg == TPOS_QUARTERS) ? `TPOS_QUART_CAP : `TPOS_FULL;
   wire [10:0] lim       = (cap < mvlim_reg) ? cap : mvlim_reg;
   wire [10:0] dly_ticks = {1'b0, dly_act_reg[10:1]};
   wire [2:0]  n_slots   = (meth_act_reg == TPOS_HALVES) ? 3'h2 :
                           (meth_act_reg == TPOS_QUARTERS) ? 3'h4 : 3'h1;

   assign sched_active_o   = sched_on;
   assign self_tuning_en_o = streq_reg && (meth_act_reg == TPOS_NO_OFFSET);
   assign ack_o            = ack_reg;

   assign rd_data = (adr_i == `TPOS_CTRL_ADR)   ? {29'h0, streq_reg, 1'b0, run_reg} :
                    (adr_i == `TPOS_STATUS_ADR) ? {20'h0, 4'(pulse_o), 2'h0,
                                                   meth_act_reg, 2'h0, self_tuning_en_o,
                                                   sched_on} :
                    (adr_i == `TPOS_SCHED_ADR)  ? {5'h0, dly_pend_reg, 14'h0, meth_pend_reg} :
                    (adr_i == `TPOS_MINW_ADR)   ? {22'h0, minw_reg} :
                    (adr_i == `TPOS_MVLIM_ADR)  ? {21'h0, mvlim_reg} :
                    out_hit                     ? rd_out[out_idx] : 32'h0;

   // Bus slave and common registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_o   <= 32'h0;
      end
      else
      begin
         ack_reg <= req;
         dat_o   <= req ? rd_data : dat_o;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_reg       <= 1'b0;
         streq_reg     <= 1'b0;
         minw_reg      <= `TPOS_MINW_RST;
         mvlim_reg     <= `TPOS_FULL;
         meth_pend_reg <= TPOS_NO_OFFSET;
         dly_pend_reg  <= `TPOS_DLY_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            run_reg   <= dat_i[`TPOS_CTRL_RUN];
            streq_reg <= dat_i[`TPOS_CTRL_STREQ];
         end
         if (wr_minw && !run_reg && minw_ok)
            minw_reg <= dat_i[9:0];
         if (wr_mvlim && mvlim_ok)
            mvlim_reg <= dat_i[10:0];
         if (wr_sched && meth_ok && dly_ok)
         begin
            meth_pend_reg <= meth_new;
            dly_pend_reg  <= {dly_new[10:1], 1'b0};
         end
      end
   end

   // Active scheduling settings load only at reset or soft reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meth_act_reg <= TPOS_NO_OFFSET;
         dly_act_reg  <= `TPOS_DLY_RST;
      end
      else if (soft_rst)
      begin
         meth_act_reg <= meth_pend_reg;
         dly_act_reg  <= dly_pend_reg;
      end
   end

   // 2 ms tick prescaler
   logic [$clog2(TICK_CYCLES+1)-1:0] pre_reg;
   wire tick = (pre_reg == ($bits(pre_reg))'(TICK_CYCLES - 1));

   always_ff @(posedge clk_i)
   begin
      if (rst_i || soft_rst)
         pre_reg <= '0;
      else
         pre_reg <= tick ? '0 : pre_reg + 1'b1;
   end

   // Per-output shaping
   logic [CW-1:0] cnt_reg  [N_OUT];
   logic [CW-1:0] on_reg   [N_OUT];
   logic [CW-1:0] base_len [N_OUT];
   logic [CW-1:0] on_next  [N_OUT];
   logic          pstart   [N_OUT];
   tpos_pct_t     shaped   [N_OUT];
   tpos_pct_t     capped   [N_OUT];
   logic          clamp_en [N_OUT];

   wire [CW-1:0] sched_len = base_len[0] + CW'(n_slots) * CW'(dly_ticks);

   for (genvar k = 0; k < N_OUT; k++)
   begin : g_out
      wire [10:0]    mv_raw  = manipulated_value_i[k*11 +: 11];
      wire [10:0]    mv      = (mv_raw > `TPOS_FULL) ? `TPOS_FULL : mv_raw;
      wire [10:0]    scaled  = assigned_pid_i[k] ? scale_pct(mv, hi_reg[k], lo_reg[k], dp_reg[k])
                                                 : mv;
      wire [6:0]     per_sel = sched_on ? per_reg[0] : per_reg[k];
      wire [CW-1:0]  own_len = (per_sel == 7'h0) ? CW'(`TPOS_HALF_S_TICKS)
                                                 : CW'(per_sel) * CW'(`TPOS_TICKS_PER_S);
      wire [CW-1:0]  len     = sched_on ? sched_len : own_len;
      wire [CW-1:0]  cnt     = sched_on ? cnt_reg[0] : cnt_reg[k];
      wire [31:0]    prod    = 32'(own_len) * 32'(shaped[k]);
      wire [CW-1:0]  on_raw  = CW'(prod / 32'(`TPOS_FULL));
      wire [1:0]     slot    = (meth_act_reg == TPOS_HALVES) ? 2'(k % 2) : 2'(k);
      wire [31:0]    slot_w  = 32'(own_len) * 32'(cap) / 32'(`TPOS_FULL);
      wire [CW-1:0]  start   = CW'(slot) * (CW'(slot_w) + CW'(dly_ticks));

      assign base_len[k] = own_len;
      assign capped[k]   = (sched_on && scaled > lim) ? lim : scaled;
      assign clamp_en[k] = assigned_pid_i[k] && !LINEAR_MASK[k];
      assign shaped[k]   = !clamp_en[k] ? capped[k] :
                           (capped[k] < 11'(minw_reg)) ? 11'h0 :
                           (capped[k] >= `TPOS_FULL - 11'(minw_reg)) ? `TPOS_FULL :
                           capped[k];
      assign on_next[k]  = (shaped[k] == 11'h0) ? '0 :
                           (on_raw == '0) ? CW'(1) : on_raw;
      assign pstart[k]   = tick && (cnt == len - 1'b1);

      always_ff @(posedge clk_i)
      begin
         if (rst_i || soft_rst)
            cnt_reg[k] <= '0;
         else if (tick)
            cnt_reg[k] <= (cnt_reg[k] >= len - 1'b1) ? '0 : cnt_reg[k] + 1'b1;
      end

      always_ff @(posedge clk_i)
      begin
         if (rst_i || soft_rst)
            on_reg[k] <= '0;
         else if (pstart[k])
            on_reg[k] <= on_next[k];
      end

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
            pulse_o[k] <= 1'b0;
         else
            pulse_o[k] <= sched_on ? (cnt >= start && cnt < start + on_reg[k])
                                   : (cnt < on_reg[k]);
      end

      wire wr_out = wr && !run_reg && out_hit && (out_idx == 2'(k)) && lim_ok;

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            per_reg[k] <= `TPOS_PER_RST;
            hi_reg[k]  <= `TPOS_HI_RST;
            lo_reg[k]  <= `TPOS_LO_RST;
            dp_reg[k]  <= 2'h0;
         end
         else if (wr_out)
         begin
            case (out_fld)
               `TPOS_PER_OFS: per_reg[k] <= (dat_i[6:0] <= `TPOS_PER_MAX) ? dat_i[6:0]
                                                                           : per_reg[k];
               `TPOS_HI_OFS:  hi_reg[k]  <= dat_i[15:0];
               `TPOS_LO_OFS:  lo_reg[k]  <= dat_i[15:0];
               `TPOS_DP_OFS:  dp_reg[k]  <= dat_i[1:0];
               default:       dp_reg[k]  <= dp_reg[k];
            endcase
         end
      end

      assign rd_out[k] = (out_fld == `TPOS_PER_OFS) ? {25'h0, per_reg[k]} :
                         (out_fld == `TPOS_HI_OFS)  ? {{16{hi_reg[k][15]}}, hi_reg[k]} :
                         (out_fld == `TPOS_LO_OFS)  ? {{16{lo_reg[k][15]}}, lo_reg[k]} :
                                                      {30'h0, dp_reg[k]};
   end

   for (genvar k = N_OUT; k < 4; k++)
   begin : g_pad
   end

   // Checks
   property p_wb_ack;
      @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle after request");

   property p_minw_locked;
      @(posedge clk_i) disable iff (rst_i)
      (run_reg && wr_minw) |=> $stable(minw_reg);
   endproperty
   a_minw_locked: assert property (p_minw_locked) else $error("min width changed while running");

   property p_full_off;
      @(posedge clk_i) disable iff (rst_i)
      (pstart[0] && clamp_en[0] && capped[0] < 11'(minw_reg)) |=> (on_reg[0] == '0);
   endproperty
   a_full_off: assert property (p_full_off) else $error("output not held off below min width");

   property p_full_on;
      @(posedge clk_i) disable iff (rst_i)
      (pstart[0] && !soft_rst && !sched_on && clamp_en[0]
       && capped[0] >= `TPOS_FULL - 11'(minw_reg))
      |=> (on_reg[0] == base_len[0]);
   endproperty
   a_full_on: assert property (p_full_on) else $error("output not held on above limit");

   property p_sched_latched;
      @(posedge clk_i) disable iff (rst_i)
      (wr_sched && !soft_rst) |=> $stable(meth_act_reg) && $stable(dly_act_reg);
   endproperty
   a_sched_latched: assert property (p_sched_latched) else $error("schedule changed early");

   property p_st_off;
      @(posedge clk_i) disable iff (rst_i)
      (meth_act_reg != TPOS_NO_OFFSET) |-> !self_tuning_en_o;
   endproperty
   a_st_off: assert property (p_st_off) else $error("self tuning on while scheduling");

   property p_std_needed;
      @(posedge clk_i) disable iff (rst_i)
      !(&std_mode_i) |-> !sched_active_o;
   endproperty
   a_std_needed: assert property (p_std_needed) else $error("scheduling without std mode");

   property p_on_held;
      @(posedge clk_i) disable iff (rst_i)
      (!pstart[0] && !soft_rst) |=> $stable(on_reg[0]);
   endproperty
   a_on_held: assert property (p_on_held) else $error("on time changed mid period");

   property p_cap;
      @(posedge clk_i) disable iff (rst_i)
      sched_on |-> (capped[0] <= cap);
   endproperty
   a_cap: assert property (p_cap) else $error("scheduled value above cap");

   property p_off_zero;
      @(posedge clk_i) disable iff (rst_i)
      (!sched_on && on_reg[0] == '0 && $stable(on_reg[0])) |=> !pulse_o[0];
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("output on with zero on time");

endmodule : tpos_shaper
`default_nettype wire

// file: sim/tpos_relay_model.sv
// Relay-side model of the shaper: counts on cycles of each switch and cycles with overlap.
// Assumes pulse_i synchronous to clk_i; clr_i zeroes all counts at an edge.
`default_nettype none
module tpos_relay_model
#(
   parameter int N = 4
)
(
   // Clock and clear
   input  wire logic          clk_i,
   input  wire logic          clr_i,
   // Switch drive
   input  wire logic [N-1:0]  pulse_i,
   // Counts
   output logic [N-1:0][15:0] on_cnt_o,
   output logic [15:0]        overlap_o
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_i)
   begin
      for (int k = 0; k < N; k++)
      begin
         if (clr_i)
            on_cnt_o[k] <= '0;
         else if (pulse_i[k])
            on_cnt_o[k] <= on_cnt_o[k] + 16'h0001;
      end
      if (clr_i)
         overlap_o <= '0;
      else if ($countones(pulse_i) > 1)
         overlap_o <= overlap_o + 16'h0001;
   end
endmodule : tpos_relay_model
`default_nettype wire

// file: sim/tpos_shaper_test.sv
// Self-checking bench of the output shaper: Wishbone tasks, relay counts per period.
// Assumes TICK_CYCLES of 4, so a 0.5 s period is 1000 clocks and 2 s is 4000.
`default_nettype none
`include "tpos_consts.svh"
module tpos_shaper_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk_i;
   logic              rst_i;
   logic              cyc_i;
   logic              stb_i;
   logic              we_i;
   logic [7:0]        adr_i;
   logic [3:0]        sel_i;
   logic [31:0]       dat_i;
   logic [31:0]       dat_o;
   logic              ack_o;
   logic [43:0]       mv;
   logic [3:0]        apid;
   logic [3:0]        stdm;
   logic [3:0]        pulse_o;
   logic              st_en;
   logic              sch_act;
   logic              clr;
   logic [3:0][15:0]  cnt;
   logic [15:0]       ovl;
   logic [3:0][15:0]  snap;
   logic [15:0]       snap_ovl;
   int                miscompares;
   int                comparisons;
   tpos_shaper #(.TICK_CYCLES(4)) i_tpos_shaper (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .manipulated_value_i(mv), .assigned_pid_i(apid), .std_mode_i(stdm),
      .pulse_o(pulse_o), .self_tuning_en_o(st_en), .sched_active_o(sch_act));
   tpos_relay_model i_tpos_relay_model (
      .clk_i(clk_i), .clr_i(clr), .pulse_i(pulse_o), .on_cnt_o(cnt), .overlap_o(ovl));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic wrap_up;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            miscompares++;
            $display("ERROR ack_o expected 1 seen %b", ack_o);
            wrap_up();
         end
         @(posedge clk_i);
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, exp, q);
   endtask : rd
   task automatic meas(input int settle, input int win);
      repeat (settle) @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (win) @(posedge clk_i);
      #1;
      snap = cnt;
      snap_ovl = ovl;
      @(posedge clk_i);
   endtask : meas
   task automatic t_reset_and_limits;
      rd("minw", `TPOS_MINW_ADR, 32'h0000000A);
      rd("sched", `TPOS_SCHED_ADR, 32'h000A0000);
      rd("mvlim", `TPOS_MVLIM_ADR, 32'h000003E8);
      rd("per3", 8'h50, 32'h00000002);
      rd("hi3", 8'h54, 32'h00000064);
      rd("lo3", 8'h58, 32'h00000000);
      rd("dp3", 8'h5C, 32'h00000000);
      rd("unmapped", 8'h1C, 32'h00000000);
      wr(`TPOS_MINW_ADR, 32'h000001F5);
      rd("minw_501", `TPOS_MINW_ADR, 32'h0000000A);
      wr(`TPOS_SCHED_ADR, 32'h00000003);
      rd("sched_3", `TPOS_SCHED_ADR, 32'h000A0000);
      wr(8'h24, 32'h00002710);
      rd("hi_10000", 8'h24, 32'h00000064);
      wr(8'h24, 32'hFFFFF831);
      rd("hi_min", 8'h24, 32'hFFFFF831);
      wr(8'h5C, 32'h00000003);
      rd("dp_3", 8'h5C, 32'h00000003);
      wr(8'h5C, 32'h00000000);
   endtask : t_reset_and_limits
   task automatic t_plain_pulses;
      for (int k = 0; k < 4; k++)
         wr(8'h20 + 8'(k * 16), 32'h0);
      wr(8'h24, 32'h00000050);
      wr(`TPOS_MINW_ADR, 32'h00000064);
      apid <= 4'b1101;
      mv <= {11'd80, 11'd950, 11'd50, 11'd400};
      meas(2000, 2000);
      chk("scaled_half", 32'd1000, 32'(snap[0]));
      chk("no_clamp", 32'd96, 32'(snap[1]));
      chk("full_on", 32'd2000, 32'(snap[2]));
      chk("full_off", 32'd0, 32'(snap[3]));
      mv[10:0] <= 11'd60;
      meas(1200, 1000);
      chk("off_scaled", 32'd0, 32'(snap[0]));
      wr(`TPOS_CTRL_ADR, 32'h00000001);
      wr(`TPOS_MINW_ADR, 32'h00000000);
      rd("minw_run", `TPOS_MINW_ADR, 32'h00000064);
      wr(`TPOS_CTRL_ADR, 32'h00000000);
      wr(`TPOS_MINW_ADR, 32'h00000000);
      mv[43:33] <= 11'd1;
      mv[10:0] <= 11'd1000;
      meas(2000, 2000);
      chk("one_tick", 32'd8, 32'(snap[3]));
      chk("full_on_scaled", 32'd2000, 32'(snap[0]));
   endtask : t_plain_pulses
   task automatic t_halves;
      logic [31:0] q;
      wr(8'h24, 32'h00000064);
      apid <= 4'hF;
      wr(`TPOS_MVLIM_ADR, 32'h0000012C);
      wr(`TPOS_SCHED_ADR, 32'h00000001);
      wb(1'b0, `TPOS_STATUS_ADR, 32'h0, q);
      chk("method_wait", 32'h0, q & 32'h00000033);
      wr(`TPOS_CTRL_ADR, 32'h00000004);
      chk("st_before", 32'h1, 32'(st_en));
      wr(`TPOS_CTRL_ADR, 32'h00000006);
      chk("st_sched", 32'h0, 32'(st_en));
      chk("sched_on", 32'h1, 32'(sch_act));
      mv <= {4{11'd1000}};
      meas(2000, 2000);
      for (int k = 0; k < 4; k++)
         chk("half_cap", 32'd600, 32'(snap[k]));
      stdm <= 4'b1011;
      @(posedge clk_i);
      #1;
      chk("sched_std", 32'h0, 32'(sch_act));
      @(posedge clk_i);
      stdm <= 4'hF;
   endtask : t_halves
   task automatic t_quarters;
      wr(`TPOS_SCHED_ADR, 32'h000B0002);
      rd("dly_even", `TPOS_SCHED_ADR, 32'h000A0002);
      wr(`TPOS_MVLIM_ADR, 32'h000003E8);
      wr(8'h20, 32'h00000002);
      wr(8'h30, 32'h00000001);
      wr(`TPOS_CTRL_ADR, 32'h00000002);
      meas(8160, 8160);
      for (int k = 0; k < 4; k++)
         chk("quarter_on", 32'd2000, 32'(snap[k]));
      chk("overlap", 32'd0, 32'(snap_ovl));
   endtask : t_quarters
   initial
   begin
      miscompares = 0;
      comparisons = 0;
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0;
      mv = 44'h0;
      apid = 4'hF;
      stdm = 4'hF;
      clr = 1'b0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_and_limits();
      t_plain_pulses();
      t_halves();
      t_quarters();
      wrap_up();
   end
endmodule : tpos_shaper_test
`default_nettype wire
